// ===== evpu_consts.svh
// evpu_consts.svh - offsets, reset values and vector layout of the
// exception vector priority unit.
// assumes: included by bare name from the top design file and the bench.
`ifndef EVPU_CONSTS_SVH
`define EVPU_CONSTS_SVH

// register byte offsets on the register bus
`define EVPU_OFS_BASE     32'h0000_0000
`define EVPU_OFS_STAT     32'h0000_0004

// vector base byte: reset value and forced value in debug
`define EVPU_BASE_RST     8'hFF
`define EVPU_DBG_BASE     8'hFF

// low byte offsets above the vector base
`define EVPU_VO_SPUR      8'h80
`define EVPU_VO_IBIT0     8'h82
`define EVPU_VO_IBIT_TOP  8'hF2
`define EVPU_VO_X         8'hF4
`define EVPU_VO_SWI       8'hF6
`define EVPU_VO_TRAP      8'hF8

// fixed system reset vectors
`define EVPU_V_RST_MAIN   16'hFFFE
`define EVPU_V_RST_CLKMON 16'hFFFC
`define EVPU_V_RST_WDOG   16'hFFFA

// i-bit maskable sources: slots 0x82..0xF2, index width
`define EVPU_N_IBIT       57
`define EVPU_IDX_W        6

// bus response codes
`define EVPU_RESP_OKAY    2'h0
`define EVPU_RESP_DECERR  2'h3

`endif

// ===== evpu_pkg.sv
// evpu_pkg.sv - types shared by the exception vector priority unit.
// assumes: nothing beyond a SystemVerilog compiler.
`default_nettype none

package evpu_pkg;
    // kind of source that won the last vector fetch
    typedef enum logic [2:0] {
        src_spur,
        src_ibit,
        src_xbit,
        src_swi,
        src_trap,
        src_wdog,
        src_clkmon,
        src_main
    } evpu_src_t;
endpackage : evpu_pkg

`default_nettype wire

// ===== evpu_prio.sv
// evpu_prio.sv - finds the highest set bit of a request vector.
// assumes: purely combinational, same clock domain as its user.
`default_nettype none

module evpu_prio #(
    parameter int N = 57,
    parameter int W = 6
) (
    // request vector in
    input  wire logic [N-1:0] req,
    // result
    output logic              any,
    output logic [W-1:0]      idx
);
    // ascending scan, so the last (highest) set bit wins
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = 0; i < N; i++) begin
            if (req[i]) begin
                any = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule : evpu_prio

`default_nettype wire

// ===== evpu_top.sv
// evpu_top.sv - exception vector priority unit: priority decode of all
// pending exceptions, vector formation, stop wake-up and register slave.
// assumes: request inputs come from logic on mclk; stop_wakeup is the only
// combinational output, since mclk is stopped in stop mode.
`include "evpu_consts.svh"
`default_nettype none

module evpu_top (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    // axi4-lite write address and data
    input  wire logic [31:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // axi4-lite read
    input  wire logic [31:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // exception requests
    input  wire logic [`EVPU_N_IBIT-1:0] ibit_req,
    input  wire logic [`EVPU_N_IBIT-1:0] ibit_local_en,
    input  wire logic                    xbit_req,
    input  wire logic                    software_interrupt_request,
    input  wire logic                    trap_req,
    input  wire logic                    rst_main_req,
    input  wire logic                    rst_clkmon_req,
    input  wire logic                    watchdog_timeout,
    // cpu side
    input  wire logic                    cpu_flag_i_mask,
    input  wire logic                    cpu_flag_x_mask,
    input  wire logic                    background_debug_state,
    input  wire logic                    vec_fetch,
    output logic                         vec_valid,
    output logic [15:0]                  vec_addr,
    output logic                         stop_wakeup
);
    // reset synchroniser
    logic                      rst_q1;         // first stage, only to rst_n
    logic                      rst_n;          // released reset copy
    // register state
    logic [7:0]                vector_base, next_vector_base; // base byte
    evpu_pkg::evpu_src_t       last_src, next_last_src; // last winner
    logic [15:0]               next_vec_addr;
    logic                      next_vec_valid;
    // bus slave state
    logic                      aw_hold, next_aw_hold; // write address held
    logic                      w_hold, next_w_hold;   // write data held
    logic [31:0]               aw_addr_q, next_aw_addr_q;
    logic [31:0]               w_data_q, next_w_data_q;
    logic [3:0]                w_strb_q, next_w_strb_q;
    logic                      next_awready, next_wready;
    logic                      next_bvalid, next_arready, next_rvalid;
    logic [1:0]                next_bresp, next_rresp;
    logic [31:0]               next_rdata;
    // priority decode
    logic                      x_pend;         // unmasked x request
    logic                      rst_any;        // any reset cause
    logic [`EVPU_N_IBIT-1:0]   ibit_elig;      // eligible i-bit requests
    logic                      ibit_any;
    logic [`EVPU_IDX_W-1:0]    ibit_idx;       // highest eligible index
    logic [7:0]                upper;          // upper vector byte
    logic [15:0]               win_vec;        // vector if fetched now
    evpu_pkg::evpu_src_t       win_src;
    logic                      do_write;
    // reset release through two flip-flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end
    // eligibility of i-bit requests
    always_comb begin
        x_pend    = xbit_req && !cpu_flag_x_mask;
        rst_any   = rst_main_req || rst_clkmon_req || watchdog_timeout;
        ibit_elig = ibit_req & ibit_local_en;
        if (cpu_flag_i_mask || software_interrupt_request || trap_req ||
            x_pend) begin
            ibit_elig = '0;
        end
    end
    // highest eligible i-bit source
    evpu_prio #(
        .N (`EVPU_N_IBIT),
        .W (`EVPU_IDX_W)
    ) u_prio (
        .req (ibit_elig),
        .any (ibit_any),
        .idx (ibit_idx)
    );
    // winner, highest vector address first
    always_comb begin
        upper = background_debug_state ? `EVPU_DBG_BASE
                                       : vector_base;
        win_vec = {upper, `EVPU_VO_SPUR};
        win_src = evpu_pkg::src_spur;
        if (rst_main_req) begin
            win_vec = `EVPU_V_RST_MAIN;
            win_src = evpu_pkg::src_main;
        end else if (rst_clkmon_req) begin
            win_vec = `EVPU_V_RST_CLKMON;
            win_src = evpu_pkg::src_clkmon;
        end else if (watchdog_timeout) begin
            win_vec = `EVPU_V_RST_WDOG;
            win_src = evpu_pkg::src_wdog;
        end else if (trap_req) begin
            win_vec = {upper, `EVPU_VO_TRAP};
            win_src = evpu_pkg::src_trap;
        end else if (software_interrupt_request) begin
            win_vec = {upper, `EVPU_VO_SWI};
            win_src = evpu_pkg::src_swi;
        end else if (x_pend) begin
            win_vec = {upper, `EVPU_VO_X};
            win_src = evpu_pkg::src_xbit;
        end else if (ibit_any) begin
            win_vec = {upper, 8'(`EVPU_VO_IBIT0 +
                      {1'b0, ibit_idx, 1'b0})};
            win_src = evpu_pkg::src_ibit;
        end
    end
    // vector answer: sampled in the fetch cycle, held until next fetch
    always_comb begin
        next_vec_valid = vec_fetch;
        next_vec_addr  = vec_addr;
        next_last_src  = last_src;
        if (vec_fetch) begin
            next_vec_addr = win_vec;
            next_last_src = win_src;
        end
    end
    // wake-up works without mclk, from raw requests
    always_comb begin
        stop_wakeup = xbit_req ||
                      (|(ibit_req & ibit_local_en) &&
                       !cpu_flag_i_mask);
    end
    // write path: address and data taken in either order
    always_comb begin
        next_aw_hold   = aw_hold;
        next_w_hold    = w_hold;
        next_aw_addr_q = aw_addr_q;
        next_w_data_q  = w_data_q;
        next_w_strb_q  = w_strb_q;
        next_bvalid    = s_axi_bvalid;
        next_bresp     = s_axi_bresp;
        next_vector_base = vector_base;
        do_write       = aw_hold && w_hold && !s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_hold   = 1'b1;
            next_aw_addr_q = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_hold   = 1'b1;
            next_w_data_q = s_axi_wdata;
            next_w_strb_q = s_axi_wstrb;
        end
        // response leaves on bready
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // both halves present: commit and answer
        if (do_write) begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `EVPU_RESP_OKAY;
            if (aw_addr_q == `EVPU_OFS_BASE) begin
                if (w_strb_q[0]) begin
                    next_vector_base = w_data_q[7:0];
                end
            end else if (aw_addr_q != `EVPU_OFS_STAT) begin
                next_bresp = `EVPU_RESP_DECERR;    // unmapped
            end
        end
        next_awready = !next_aw_hold;
        next_wready  = !next_w_hold;
    end
    // read path: one read at a time
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `EVPU_RESP_OKAY;
            if (s_axi_araddr == `EVPU_OFS_BASE) begin
                next_rdata = {24'h00_0000, vector_base};
            end else if (s_axi_araddr == `EVPU_OFS_STAT) begin
                // pending flag, last winner, last vector
                next_rdata = {12'h000, win_src != evpu_pkg::src_spur,
                              last_src, vec_addr};
            end else begin
                next_rdata = 32'h0000_0000;
                next_rresp = `EVPU_RESP_DECERR;
            end
        end
        next_arready = !next_rvalid;
    end
    // all registers but the synchroniser; base reloads on every nrst reset, not on reset requests
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vector_base   <= `EVPU_BASE_RST;
            last_src      <= evpu_pkg::src_spur;
            vec_valid     <= 1'b0;
            vec_addr      <= 16'h0000;
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr_q     <= 32'h0000_0000;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            vector_base   <= next_vector_base;
            last_src      <= next_last_src;
            vec_valid     <= next_vec_valid;
            vec_addr      <= next_vec_addr;
            aw_hold       <= next_aw_hold;
            w_hold        <= next_w_hold;
            aw_addr_q     <= next_aw_addr_q;
            w_data_q      <= next_w_data_q;
            w_strb_q      <= next_w_strb_q;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_fetch_quiet;
        vec_fetch && !rst_any && !trap_req && !software_interrupt_request;
    endsequence
    sequence s_wr_ready;
        aw_hold && w_hold && !s_axi_bvalid;
    endsequence
    chk_fetch_answer: assert property (
        vec_fetch |=> vec_valid && vec_addr == $past(win_vec))
        else $error("vector not answered one cycle after fetch");
    chk_spur_vector: assert property (
        s_fetch_quiet ##0 (!x_pend && !ibit_any && !background_debug_state)
        |=> vec_addr == {$past(vector_base), `EVPU_VO_SPUR})
        else $error("spurious vector wrong");
    chk_dbg_upper: assert property (
        (vec_fetch && !rst_any && background_debug_state)
        |=> vec_addr[15:8] == `EVPU_DBG_BASE)
        else $error("debug did not force upper byte");
    chk_rst_main: assert property (
        (vec_fetch && rst_main_req) |=> vec_addr == `EVPU_V_RST_MAIN)
        else $error("main reset vector wrong");
    chk_wdog_vector: assert property (
        (vec_fetch && watchdog_timeout && !rst_main_req &&
        !rst_clkmon_req) |=> vec_addr == `EVPU_V_RST_WDOG)
        else $error("watchdog reset vector wrong");
    chk_trap_wins: assert property (
        (vec_fetch && trap_req && !rst_any) |=> vec_addr[7:0] == `EVPU_VO_TRAP)
        else $error("trap did not win");
    chk_swi_vector: assert property (
        (vec_fetch && software_interrupt_request && !trap_req &&
        !rst_any) |=> vec_addr[7:0] == `EVPU_VO_SWI)
        else $error("software vector wrong");
    chk_x_preempt: assert property (
        s_fetch_quiet ##0 x_pend |=> vec_addr[7:0] == `EVPU_VO_X)
        else $error("unmasked x did not win");
    chk_ibit_range: assert property (
        s_fetch_quiet ##0 (!x_pend && ibit_any)
        |=> vec_addr[7:0] >= `EVPU_VO_IBIT0 &&
            vec_addr[7:0] <= `EVPU_VO_IBIT_TOP && !vec_addr[0])
        else $error("i-bit vector out of range");
    chk_imask_block: assert property (
        (cpu_flag_i_mask || x_pend) |-> ibit_elig == '0)
        else $error("masked i-bit request eligible");
    chk_wake_x: assert property (
        xbit_req |-> stop_wakeup)
        else $error("x request did not wake");
    chk_base_reset: assert property (
        $rose(rst_n) |-> vector_base == `EVPU_BASE_RST)
        else $error("base byte not reset");
    chk_wr_answer: assert property (
        s_wr_ready |=> s_axi_bvalid)
        else $error("write not answered");
endmodule : evpu_top

`default_nettype wire

// ===== evpu_cpu_model.sv
// evpu_cpu_model.sv - cpu side of the vector fetch interface
// assumes: ask is a one-cycle strobe from the bench on mclk
`default_nettype none

module evpu_cpu_model (
    // clock
    input  wire logic        mclk,
    // bench side
    input  wire logic        ask,
    output logic [15:0]      got,
    output logic             got_stb,
    // vector fetch interface
    output logic             vec_fetch,
    input  wire logic        vec_valid,
    input  wire logic [15:0] vec_addr
);
    // one fetch per ask; answer latched on the valid pulse
    always @(posedge mclk) begin
        vec_fetch <= ask;
        got_stb <= vec_valid;
        if (vec_valid) begin
            got <= vec_addr;
        end
    end
endmodule : evpu_cpu_model

`default_nettype wire

// ===== test_exception_vector_priority_unit.sv
// test_exception_vector_priority_unit.sv - self-checking bench of evpu_top
// assumes: evpu_consts.svh, evpu_pkg, evpu_cpu_model, evpu_top compiled
`include "evpu_consts.svh"
`default_nettype none

module test_exception_vector_priority_unit;
    timeunit 1ns;
    timeprecision 1ns;
    // clock, reset, counters
    logic        mclk = 1'b0;
    logic        nrst;
    logic        clk_run = 1'b1;
    int          num_errors = 0;
    int          num_checks = 0;
    // register bus
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    // requests: dbg, xmask, imask, wdog, clkmon, main, trap, swi, x
    logic [8:0]  ctl;
    logic [`EVPU_N_IBIT-1:0] ibit_req, ibit_en;
    // cpu side
    logic        ask, got_stb, vec_fetch, vec_valid, stop_wakeup;
    logic [15:0] got, vec_addr;
    // control patterns and their vectors with base byte 0x12
    localparam logic [8:0]  nm_ctl [9] = '{9'h03F, 9'h037, 9'h027,
        9'h007, 9'h003, 9'h001, 9'h081, 9'h104, 9'h000};
    localparam logic [15:0] nm_vec [9] = '{16'hFFFE, 16'hFFFC, 16'hFFFA,
        16'h12F8, 16'h12F6, 16'h12F4, 16'h1280, 16'hFFF8, 16'h1280};

    // clock holds still while stop mode is modelled
    always #25 mclk = clk_run ? ~mclk : mclk;

    evpu_top DUT (
        .mclk(mclk), .nrst(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ibit_req(ibit_req), .ibit_local_en(ibit_en), .xbit_req(ctl[0]),
        .software_interrupt_request(ctl[1]), .trap_req(ctl[2]),
        .rst_main_req(ctl[3]), .rst_clkmon_req(ctl[4]),
        .watchdog_timeout(ctl[5]), .cpu_flag_i_mask(ctl[6]),
        .cpu_flag_x_mask(ctl[7]), .background_debug_state(ctl[8]),
        .vec_fetch(vec_fetch), .vec_valid(vec_valid),
        .vec_addr(vec_addr), .stop_wakeup(stop_wakeup)
    );

    evpu_cpu_model cpu (
        .mclk(mclk), .ask(ask), .got(got), .got_stb(got_stb),
        .vec_fetch(vec_fetch), .vec_valid(vec_valid), .vec_addr(vec_addr)
    );

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one write: address and data offered together, response awaited
    task automatic wr(input logic [31:0] a, dd, input logic [3:0] s);
        logic ad, wd;
        @(posedge mclk);
        awaddr <= a;
        wdata <= dd;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ad = 1'b0;
        wd = 1'b0;
        do begin
            @(posedge mclk);
            if (awvalid && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(ad && wd));
        do begin
            @(posedge mclk);
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    // one read: data and response taken at the rvalid edge
    task automatic rd(input logic [31:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge mclk);
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    // vector fetch through the cpu model, answer compared
    task automatic fetch(input logic [15:0] e);
        @(posedge mclk);
        ask <= 1'b1;
        @(posedge mclk);
        ask <= 1'b0;
        do begin
            @(negedge mclk);
        end while (got_stb !== 1'b1);
        chk(32'(got), 32'(e));
        chk(32'(vec_valid), 32'h0);
    endtask : fetch

    // apply a request set
    task automatic put(input logic [8:0] c, input logic [56:0] q, en);
        ctl <= c;
        ibit_req <= q;
        ibit_en <= en;
    endtask : put

    // apply a request set, then fetch
    task automatic ib(input logic [8:0] c, input logic [56:0] q, en,
                      input logic [15:0] e);
        @(posedge mclk);
        put(c, q, en);
        fetch(e);
    endtask : ib

    // apply a request set with the clock stopped, check wake-up
    task automatic wk(input logic [8:0] c, input logic [56:0] q, en,
                      input logic e);
        put(c, q, en);
        #10;
        chk(32'(stop_wakeup), 32'(e));
    endtask : wk

    // base register access kinds, strobes, unmapped places
    task automatic t_regs();
        rd(`EVPU_OFS_BASE);
        chk(d, 32'hFF);
        wr(`EVPU_OFS_BASE, 32'hFFFF_FFAB, 4'hF);
        chk(32'(r), 32'(`EVPU_RESP_OKAY));
        wr(`EVPU_OFS_BASE, 32'h0000_0055, 4'hE);
        rd(`EVPU_OFS_BASE);
        chk(d, 32'hAB);
        ib(9'h000, 57'h0, 57'h0, 16'hAB80);
        wr(32'h8, 32'h1, 4'hF);
        chk(32'(r), 32'(`EVPU_RESP_DECERR));
        rd(32'h8);
        chk(d, 32'h0);
        chk(32'(r), 32'(`EVPU_RESP_DECERR));
        $display("register test done");
    endtask : t_regs

    // reset, trap, software, x-bit and spurious vectors, debug override
    task automatic t_vectors();
        wr(`EVPU_OFS_BASE, 32'h12, 4'hF);
        for (int i = 0; i < 9; i++) begin
            ib(nm_ctl[i], 57'h0, 57'h0, nm_vec[i]);
        end
        ib(9'h004, 57'h0, 57'h0, {8'h12, `EVPU_VO_TRAP});
        rd(`EVPU_OFS_STAT);
        chk(d, {12'h0, 1'b1, evpu_pkg::src_trap, 16'h12F8});
        $display("vector test done");
    endtask : t_vectors

    // i-bit priority, enables and masks against higher requests
    task automatic t_ibit();
        wr(`EVPU_OFS_BASE, 32'h34, 4'hF);
        ib(9'h000, 57'h1, '1, 16'h3482);
        ib(9'h000, {1'b1, 55'h0, 1'b1}, '1, 16'h34F2);
        ib(9'h000, 57'h408, '1, 16'h3496);
        ib(9'h000, 57'h400, 57'h8, 16'h3480);
        ib(9'h040, 57'h400, '1, 16'h3480);
        ib(9'h001, 57'h400, '1, 16'h34F4);
        ib(9'h081, 57'h400, '1, 16'h3496);
        ib(9'h002, 57'h400, '1, 16'h34F6);
        ib(9'h004, 57'h400, '1, 16'h34F8);
        $display("i-bit test done");
    endtask : t_ibit

    // wake-up with the clock stopped
    task automatic t_wake();
        @(posedge mclk);
        clk_run = 1'b0;
        wk(9'h081, 57'h0, 57'h0, 1'b1);
        wk(9'h000, 57'h400, '1, 1'b1);
        wk(9'h040, 57'h400, '1, 1'b0);
        wk(9'h000, 57'h400, 57'h8, 1'b0);
        wk(9'h006, 57'h0, 57'h0, 1'b0);
        put(9'h000, 57'h0, 57'h0);
        #10;
        clk_run = 1'b1;
        $display("wake-up test done");
    endtask : t_wake

    // an nrst reset reloads the base byte
    task automatic t_reload();
        wr(`EVPU_OFS_BASE, 32'h5A, 4'hF);
        rd(`EVPU_OFS_BASE);
        chk(d, 32'h5A);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(`EVPU_OFS_BASE);
        chk(d, 32'hFF);
        ib(9'h000, 57'h0, 57'h0, 16'hFF80);
        $display("reload test done");
    endtask : t_reload

    // counts and verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // hang guard, far beyond the expected run
    initial begin
        #500us;
        num_errors++;
        close_out();
    end

    // main sequence
    initial begin
        nrst = 1'b0;
        ask = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 32'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        araddr = 32'h0;
        put(9'h000, 57'h0, 57'h0);
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        t_regs();
        t_vectors();
        t_ibit();
        t_wake();
        t_reload();
        close_out();
    end
endmodule : test_exception_vector_priority_unit

`default_nettype wire
